// file: clock_ctrl_consts.vh
`ifndef CLOCK_CTRL_CONSTS_VH
`define CLOCK_CTRL_CONSTS_VH
// **********
// register offsets
// **********
`define OFS_LOOP_NOISE 15'h002B
`define OFS_CLOCK_OUT 15'h002C
`define OFS_TRIG_CTRL 15'h002D
`define OFS_SYSREF_WIN 15'h002E
`define OFS_PRESCALE_OSC 15'h003D
`define OFS_FEEDBACK 15'h003E
`define OFS_HOLD_RESET 15'h005C
`define OFS_CAL_CONTROL 15'h005D
`define OFS_CAL_STATE 15'h005E
`define OFS_LOCK_STATE 15'h0208
// **********
// field positions
// **********
`define BIT_HOLD 0
`define BIT_CAL_EN 0
`define BIT_CAL_DONE 0
`define BIT_LOCKED 0
`define BIT_REPEAT_EN 0
`define BIT_AUX_OVR 1
`define BIT_TRIG_EN 0
`define BIT_TRIG_SRC 1
// **********
// reset values
// **********
`define RST_NOISE 8'h00
`define RST_PRESCALE_OSC 8'h25
`define RST_FEEDBACK 8'h10
`define RST_HOLD 8'h01
`define RST_CAL_CONTROL 8'h00
`define RST_CLOCK_OUT 8'h01
`define RST_TRIG_CTRL 8'h10
// **********
// timing
// **********
`define CLK_PERIOD_NS 8
`define CAL_TIME_NS 1000
`define CAL_CYCLES ((`CAL_TIME_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define LOCK_PERIODS 4
`define SPI_FRAME_BITS 24
`endif

// file: clock_edge_divider.v
`timescale 1ns/1ps
`include "clock_ctrl_consts.vh"
module clock_edge_divider (
    input wire clk_in,
    input wire arst_n_in,
    input wire level_in,
    input wire edge_in,
    input wire [7:0] ratio_in,
    output reg clock_out,
    output reg tick_out
);
    reg [7:0] count;
    wire [7:0] half = {1'b0, ratio_in[7:1]};
    wire wrap = (count >= ratio_in - 8'h01);

    always @(posedge clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            count <= 8'h00;
            clock_out <= 1'b0;
            tick_out <= 1'b0;
        end else begin
            tick_out <= edge_in & wrap;
            if (edge_in) begin
                count <= wrap ? 8'h00 : count + 8'h01;
            end
            // ratio 0 or 1 passes input through
            clock_out <= (ratio_in <= 8'h01) ? level_in : (count < half);
        end
    end
endmodule // clock_edge_divider

// file: clock_source_model.sv
`timescale 1ns/1ps
// **********
// board clock source
// **********
module clock_source_model #(
    parameter int OSC_HALF_NS = 24,
    parameter int REF_HALF_NS = 3840,
    parameter int DIRECT_HALF_NS = 32,
    parameter int STAMP_HALF_NS = 1200,
    parameter int SYSREF_HALF_NS = 15360
) (
    input logic loop_on_in,
    input logic ref_sel_in,
    output logic diff_clk_out,
    output logic se_ref_out,
    output logic osc_out,
    output logic stamp_out,
    output logic sysref_out
);
    logic ref_clk = 1'b0;
    logic direct = 1'b0;
    logic osc = 1'b0;
    logic stamp = 1'b0;
    logic sref = 1'b0;
    // ref is 160 osc halves: divisor 10 times feedback 16
    initial begin
        #5;
        forever #(OSC_HALF_NS) osc = ~osc;
    end
    always #(REF_HALF_NS) ref_clk = ~ref_clk;
    always #(DIRECT_HALF_NS) direct = ~direct;
    always #(STAMP_HALF_NS) stamp = ~stamp;
    always #(SYSREF_HALF_NS) sref = ~sref;
    assign osc_out = osc;
    assign stamp_out = stamp;
    assign sysref_out = sref;
    // bypass feeds the sampling rate directly
    assign diff_clk_out = loop_on_in ? (ref_sel_in ? 1'b0 : ref_clk) : direct;
    // se input idle unless the loop uses it
    assign se_ref_out = (loop_on_in && ref_sel_in) ? ref_clk : 1'b0;
endmodule // clock_source_model

// file: clock_subsystem_checker.sv
`timescale 1ns/1ps
// **********
// clock subsystem checker
// **********
module clock_subsystem_checker (
    input logic clk_in,
    input logic arst_n_in,
    input logic loop_enable_pin_in,
    input logic reference_input_select_pin_in,
    input logic power_down_pin_in,
    input logic diff_clock_in,
    input logic single_ended_reference_input_in,
    input logic spi_sen_n_in,
    input logic sample_clock_out,
    input logic dsp_clock_out,
    input logic lane_clock_out,
    input logic reference_repeat_output_out,
    input logic aux_clock_out_c_out,
    input logic aux_clock_out_d_out,
    input logic trigger_clock_output_out,
    input logic sysref_capture_out,
    input logic noise_supp_a_out,
    input logic noise_supp_b_out,
    input logic clock_ready_out
);
    default clocking cb @(posedge clk_in);
    endclocking
    default disable iff (!arst_n_in);
    logic spi_seen;
    // no frame, no trigger enable
    always_ff @(posedge clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            spi_seen <= 1'b0;
        end else if (!spi_sen_n_in) begin
            spi_seen <= 1'b1;
        end
    end
    sequence s_pd_held;
        power_down_pin_in [*6];
    endsequence
    sequence s_loop_start;
        $rose(loop_enable_pin_in);
    endsequence
    property p_pd_gate;
        s_pd_held |-> !(reference_repeat_output_out || aux_clock_out_c_out || aux_clock_out_d_out);
    endproperty
    a_pd_gate: assert property (p_pd_gate) else $error("clock out in power-down");
    property p_bypass;
        !loop_enable_pin_in [*6] |-> sample_clock_out == $past(diff_clock_in, 3);
    endproperty
    a_bypass: assert property (p_bypass) else $error("bypass clock wrong");
    property p_repeat_gate;
        reference_repeat_output_out |-> $past(loop_enable_pin_in, 3) && !$past(power_down_pin_in, 3);
    endproperty
    a_repeat_gate: assert property (p_repeat_gate) else $error("repeat not gated");
    property p_repeat_src;
        reference_repeat_output_out |-> ($past(reference_input_select_pin_in, 3) ?
            $past(single_ended_reference_input_in, 3) : $past(diff_clock_in, 3));
    endproperty
    a_repeat_src: assert property (p_repeat_src) else $error("repeat source wrong");
    property p_dsp_lane;
        dsp_clock_out == sample_clock_out && lane_clock_out == sample_clock_out;
    endproperty
    a_dsp_lane: assert property (p_dsp_lane) else $error("derived clocks differ");
    property p_trig_off;
        !spi_seen |-> !trigger_clock_output_out;
    endproperty
    a_trig_off: assert property (p_trig_off) else $error("trigger on at startup");
    property p_ready_wait;
        s_loop_start |-> ##4 (!clock_ready_out) [*8];
    endproperty
    a_ready_wait: assert property (p_ready_wait) else $error("ready too early");
    property p_sysref;
        $changed(sysref_capture_out) |-> ##[0:1] sample_clock_out;
    endproperty
    a_sysref: assert property (p_sysref) else $error("sysref off clock edge");
    property p_noise;
        spi_sen_n_in [*8] |-> $stable(noise_supp_a_out) && $stable(noise_supp_b_out);
    endproperty
    a_noise: assert property (p_noise) else $error("noise bits moved idle");
endmodule // clock_subsystem_checker
bind converter_clock_subsystem_ctrl clock_subsystem_checker u_chk (.*);

// file: converter_clock_subsystem_ctrl.v
// Notes on behaviour
// - loop pin selects loop clock or differential input.
// - select pin picks differential or single-ended reference with loop on; bypass always uses differential.
// - sample rate is oscillator over divisor product.
// - lock when reference times feedback equals sample rate.
// - divider ratios writable at 0x3D and 0x3E.
// - calibration runs when hold clears with enable set and loop pin on.
// - finished flag at 0x5E, lock flag at 0x208.
// - noise suppression bits at 0x2B.
// - reference repeat with loop on, gated by repeat enable.
// - power-down stops repeat and aux outputs.
// - aux outputs carry reference copies, pins or registers.
// - trigger output from timestamp or serializer per mode.
// - trigger output off until host enables it.
// - serializer source divided by receiver divider.
// - sampling clock drives processing and lane clock.
// - sysref captured on chosen clock, window measures margins.
`timescale 1ns/1ps
`include "clock_ctrl_consts.vh"
module converter_clock_subsystem_ctrl (
    input wire clk_in,
    input wire arst_n_in,
    input wire loop_enable_pin_in,
    input wire reference_input_select_pin_in,
    input wire power_down_pin_in,
    input wire [1:0] aux_clock_config_pins_in,
    input wire diff_clock_in,
    input wire single_ended_reference_input_in,
    input wire oscillator_in,
    input wire timestamp_input_in,
    input wire sysref_in,
    input wire spi_sclk_in,
    input wire spi_sdi_in,
    input wire spi_sen_n_in,
    output reg spi_sdo_out,
    output reg sample_clock_out,
    output reg dsp_clock_out,
    output reg lane_clock_out,
    output reg reference_repeat_output_out,
    output reg aux_clock_out_c_out,
    output reg aux_clock_out_d_out,
    output reg trigger_clock_output_out,
    output reg sysref_capture_out,
    output reg noise_supp_a_out,
    output reg noise_supp_b_out,
    output reg clock_ready_out
);
    // **********
    // helpers
    // **********
    function rise;
        input cur;
        input last;
        begin
            rise = cur & ~last;
        end
    endfunction

    function [7:0] mode_ratio;
        input [1:0] mode;
        begin
            case (mode)
                2'h2: mode_ratio = 8'h02;
                2'h3: mode_ratio = 8'h04;
                default: mode_ratio = 8'h01;
            endcase
        end
    endfunction

    // **********
    // pin synchronisers
    // **********
    reg [12:0] pin_meta;
    reg [12:0] pin_sync;
    reg [12:0] pin_last;
    always @(posedge clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            pin_meta <= 13'h1000;
            pin_sync <= 13'h1000;
            pin_last <= 13'h1000;
        end else begin
            pin_meta <= {spi_sen_n_in, spi_sdi_in, spi_sclk_in, sysref_in,
                timestamp_input_in, oscillator_in, single_ended_reference_input_in,
                diff_clock_in, aux_clock_config_pins_in, power_down_pin_in,
                reference_input_select_pin_in, loop_enable_pin_in};
            pin_sync <= pin_meta;
            pin_last <= pin_sync;
        end
    end
    wire loop_on = pin_sync[0];
    wire ref_sel = pin_sync[1];
    wire pd = pin_sync[2];
    wire [1:0] cfg = pin_sync[4:3];
    wire diff_clk = pin_sync[5];
    wire se_ref = pin_sync[6];
    wire osc = pin_sync[7];
    wire ts = pin_sync[8];
    wire sysref = pin_sync[9];
    wire sclk_rise = rise(pin_sync[10], pin_last[10]);
    wire sclk_fall = rise(pin_last[10], pin_sync[10]);
    wire sdi = pin_sync[11];
    wire spi_active = ~pin_sync[12];

    // **********
    // registers
    // **********
    reg [7:0] loop_noise_control;
    reg [7:0] prescale_osc_divider;
    reg [7:0] feedback_divider;
    reg [7:0] loop_hold_reset_ctrl;
    reg [7:0] osc_cal_control;
    reg [7:0] clock_out_ctrl;
    reg [7:0] trigger_output_control;
    reg oscillator_cal_finished;
    wire loop_lock_flag;
    reg [3:0] setup_margin;
    reg [3:0] hold_margin;
    wire loop_hold_reset = loop_hold_reset_ctrl[`BIT_HOLD];
    wire oscillator_cal_enable = osc_cal_control[`BIT_CAL_EN];
    wire reference_repeat_enable = clock_out_ctrl[`BIT_REPEAT_EN];
    wire [7:0] vp_product = {4'h0, prescale_osc_divider[7:4]}
        * {4'h0, prescale_osc_divider[3:0]};

    // **********
    // spi slave
    // **********
    // frame: rw bit, 15 address bits, 8 data bits, msb first
    reg [22:0] shift_in;
    reg [4:0] bit_cnt;
    reg [14:0] addr;
    reg rw;
    reg [7:0] rd_shift;
    reg [7:0] read_data;
    wire [14:0] addr_now = {shift_in[13:0], sdi};
    wire wr_strobe = spi_active & sclk_rise & ~rw
        & (bit_cnt == `SPI_FRAME_BITS - 1);
    wire [7:0] wr_data = {shift_in[6:0], sdi};

    always @* begin
        case (addr_now)
            `OFS_LOOP_NOISE: read_data = loop_noise_control;
            `OFS_CLOCK_OUT: read_data = clock_out_ctrl;
            `OFS_TRIG_CTRL: read_data = trigger_output_control;
            `OFS_SYSREF_WIN: read_data = {hold_margin, setup_margin};
            `OFS_PRESCALE_OSC: read_data = prescale_osc_divider;
            `OFS_FEEDBACK: read_data = feedback_divider;
            `OFS_HOLD_RESET: read_data = loop_hold_reset_ctrl;
            `OFS_CAL_CONTROL: read_data = osc_cal_control;
            `OFS_CAL_STATE: read_data = {7'h00, oscillator_cal_finished};
            `OFS_LOCK_STATE: read_data = {7'h00, loop_lock_flag};
            default: read_data = 8'h00;
        endcase
    end

    always @(posedge clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            shift_in <= 23'h000000;
            bit_cnt <= 5'h00;
            addr <= 15'h0000;
            rw <= 1'b0;
            rd_shift <= 8'h00;
            spi_sdo_out <= 1'b0;
        end else if (!spi_active) begin
            bit_cnt <= 5'h00;
            spi_sdo_out <= 1'b0;
        end else begin
            if (sclk_rise) begin
                shift_in <= {shift_in[21:0], sdi};
                bit_cnt <= (bit_cnt == `SPI_FRAME_BITS - 1) ? 5'h00 : bit_cnt + 5'h01;
                if (bit_cnt == 5'h0F) begin
                    addr <= addr_now;
                    rw <= shift_in[14];
                    rd_shift <= read_data;
                end
            end
            if (sclk_fall && rw && bit_cnt >= 5'h10) begin
                spi_sdo_out <= rd_shift[7];
                rd_shift <= {rd_shift[6:0], 1'b0};
            end
        end
    end

    always @(posedge clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            loop_noise_control <= `RST_NOISE;
            prescale_osc_divider <= `RST_PRESCALE_OSC;
            feedback_divider <= `RST_FEEDBACK;
            loop_hold_reset_ctrl <= `RST_HOLD;
            osc_cal_control <= `RST_CAL_CONTROL;
            clock_out_ctrl <= `RST_CLOCK_OUT;
            trigger_output_control <= `RST_TRIG_CTRL;
        end else if (wr_strobe) begin
            case (addr)
                `OFS_LOOP_NOISE: loop_noise_control <= wr_data;
                `OFS_PRESCALE_OSC: prescale_osc_divider <= wr_data;
                `OFS_FEEDBACK: feedback_divider <= wr_data;
                `OFS_HOLD_RESET: loop_hold_reset_ctrl <= wr_data;
                `OFS_CAL_CONTROL: osc_cal_control <= wr_data;
                `OFS_CLOCK_OUT: clock_out_ctrl <= wr_data;
                `OFS_TRIG_CTRL: trigger_output_control <= wr_data;
                default: ;
            endcase
        end
    end

    // **********
    // clock selection
    // **********
    // bypass ignores the select pin
    wire ref_level = (loop_on & ref_sel) ? se_ref : diff_clk;
    wire ref_edge = rise(ref_level, pin_last[6] & loop_on & ref_sel
        | pin_last[5] & ~(loop_on & ref_sel));
    wire osc_edge = rise(osc, pin_last[7]);
    wire loop_clk;
    wire loop_tick;
    clock_edge_divider u_loop_div (
        .clk_in(clk_in),
        .arst_n_in(arst_n_in),
        .level_in(osc),
        .edge_in(osc_edge),
        .ratio_in(vp_product),
        .clock_out(loop_clk),
        .tick_out(loop_tick)
    );
    wire sample_level = loop_on ? loop_clk : diff_clk;
    wire sample_edge = rise(sample_level, sample_clock_out);
    reg loop_clk_last;
    loop_lock_detect u_lock (
        .clk_in(clk_in),
        .arst_n_in(arst_n_in),
        .hold_in(loop_hold_reset | ~loop_on),
        .ref_edge_in(ref_edge),
        .fs_edge_in(rise(loop_clk, loop_clk_last)),
        .feedback_in(feedback_divider),
        .locked_out(loop_lock_flag)
    );

    // **********
    // calibration sequencer
    // **********
    localparam ST_HOLD = 2'h0;
    localparam ST_CAL = 2'h1;
    localparam ST_RUN = 2'h2;
    reg [1:0] state;
    reg [15:0] cal_cnt;
    always @(posedge clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            state <= ST_HOLD;
            cal_cnt <= 16'h0000;
            oscillator_cal_finished <= 1'b0;
            loop_clk_last <= 1'b0;
        end else begin
            loop_clk_last <= loop_clk;
            case (state)
                ST_HOLD: begin
                    oscillator_cal_finished <= 1'b0;
                    cal_cnt <= 16'h0000;
                    if (!loop_hold_reset && loop_on) begin
                        state <= oscillator_cal_enable ? ST_CAL : ST_RUN;
                    end
                end
                ST_CAL: begin
                    if (loop_hold_reset) begin
                        state <= ST_HOLD;
                    end else if (cal_cnt == `CAL_CYCLES - 1) begin
                        oscillator_cal_finished <= 1'b1;
                        state <= ST_RUN;
                    end else begin
                        cal_cnt <= cal_cnt + 16'h0001;
                    end
                end
                ST_RUN: begin
                    if (loop_hold_reset || !loop_on) begin
                        state <= ST_HOLD;
                    end
                end
                default: state <= ST_HOLD;
            endcase
        end
    end

    // **********
    // output clocks
    // **********
    // pins rule aux modes unless overridden
    wire aux_ovr = clock_out_ctrl[`BIT_AUX_OVR];
    wire [1:0] c_mode = aux_ovr ? clock_out_ctrl[3:2] : cfg;
    wire [1:0] d_mode = aux_ovr ? clock_out_ctrl[5:4] : {1'b0, cfg != 2'h0};
    wire d_on = (d_mode != 2'h0) & (c_mode != 2'h0);
    wire aux_c_clk;
    wire aux_d_clk;
    wire trig_div_clk;
    clock_edge_divider u_aux_c (
        .clk_in(clk_in),
        .arst_n_in(arst_n_in),
        .level_in(ref_level),
        .edge_in(ref_edge),
        .ratio_in(mode_ratio(c_mode)),
        .clock_out(aux_c_clk),
        .tick_out()
    );
    clock_edge_divider u_aux_d (
        .clk_in(clk_in),
        .arst_n_in(arst_n_in),
        .level_in(ref_level),
        .edge_in(ref_edge),
        .ratio_in(mode_ratio(d_mode)),
        .clock_out(aux_d_clk),
        .tick_out()
    );
    // lane clock modelled at sampling rate
    clock_edge_divider u_trig (
        .clk_in(clk_in),
        .arst_n_in(arst_n_in),
        .level_in(sample_level),
        .edge_in(sample_edge),
        .ratio_in({4'h0, trigger_output_control[7:4]}),
        .clock_out(trig_div_clk),
        .tick_out()
    );

    // **********
    // timestamp, sysref window, outputs
    // **********
    reg ts_retimed;
    reg [3:0] phase;
    reg hold_meas;
    always @(posedge clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            ts_retimed <= 1'b0;
            phase <= 4'h0;
            hold_meas <= 1'b0;
            setup_margin <= 4'h0;
            hold_margin <= 4'h0;
            sysref_capture_out <= 1'b0;
            sample_clock_out <= 1'b0;
            dsp_clock_out <= 1'b0;
            lane_clock_out <= 1'b0;
            reference_repeat_output_out <= 1'b0;
            aux_clock_out_c_out <= 1'b0;
            aux_clock_out_d_out <= 1'b0;
            trigger_clock_output_out <= 1'b0;
            noise_supp_a_out <= 1'b0;
            noise_supp_b_out <= 1'b0;
            clock_ready_out <= 1'b0;
        end else begin
            if (sample_edge) begin
                ts_retimed <= ts;
                sysref_capture_out <= sysref;
                phase <= 4'h0;
            end else if (phase != 4'hF) begin
                phase <= phase + 4'h1;
            end
            // setup: cycles since last edge; hold: cycles from the last edge to the next one, not from sysref
            if (rise(sysref, pin_last[9])) begin
                setup_margin <= phase;
                hold_meas <= 1'b1;
            end else if (hold_meas && sample_edge) begin
                hold_margin <= phase;
                hold_meas <= 1'b0;
            end
            sample_clock_out <= sample_level;
            dsp_clock_out <= sample_level;
            lane_clock_out <= sample_level;
            reference_repeat_output_out <= ref_level & loop_on
                & reference_repeat_enable & ~pd;
            aux_clock_out_c_out <= aux_c_clk & (c_mode != 2'h0) & ~pd;
            aux_clock_out_d_out <= aux_d_clk & d_on & ~pd;
            trigger_clock_output_out <= trigger_output_control[`BIT_TRIG_EN]
                & (trigger_output_control[`BIT_TRIG_SRC] ? ts_retimed
                : trig_div_clk);
            noise_supp_a_out <= loop_noise_control[0];
            noise_supp_b_out <= loop_noise_control[1];
            clock_ready_out <= loop_on ? (oscillator_cal_finished
                & loop_lock_flag) : 1'b1;
        end
    end
endmodule // converter_clock_subsystem_ctrl

// file: converter_clock_subsystem_ctrl_bench.sv
`timescale 1ns/1ps
`include "clock_ctrl_consts.vh"
// **********
// bench
// **********
module converter_clock_subsystem_ctrl_bench;
    localparam int OSC_NS = 48;
    localparam int FS_NS = OSC_NS * 10;
    localparam int REF_NS = FS_NS * 16;
    logic clk_in = 1'b0;
    logic arst_n_in = 1'b0;
    logic loop_pin = 1'b0;
    logic sel_pin = 1'b0;
    logic pd_pin = 1'b0;
    logic [1:0] aux_pins = 2'b00;
    logic sclk = 1'b0;
    logic sdi = 1'b0;
    logic sen_n = 1'b1;
    logic [7:0] rd;
    logic [31:0] seed = 32'hC934;
    logic [4:0] prev = 5'h00;
    wire diff_clk, se_ref, osc, stamp, sref, sdo, smp, dsp, lane, rep, auxc, auxd, trig;
    wire cap, nsa, nsb, rdy;
    wire [4:0] mon = {smp, lane, trig, auxc, rep};
    int miscompares = 0;
    int n_checks = 0;
    int cnt[5];
    logic [14:0] ra[5] = '{`OFS_LOOP_NOISE, `OFS_PRESCALE_OSC, `OFS_FEEDBACK, `OFS_HOLD_RESET,
        `OFS_CAL_CONTROL};
    logic [7:0] rv[5] = '{`RST_NOISE, `RST_PRESCALE_OSC, `RST_FEEDBACK, `RST_HOLD, `RST_CAL_CONTROL};
    always #4 clk_in = ~clk_in;
    clock_source_model src (.loop_on_in(loop_pin), .ref_sel_in(sel_pin), .diff_clk_out(diff_clk),
        .se_ref_out(se_ref), .osc_out(osc), .stamp_out(stamp), .sysref_out(sref));
    converter_clock_subsystem_ctrl uut (.clk_in(clk_in), .arst_n_in(arst_n_in),
        .loop_enable_pin_in(loop_pin), .reference_input_select_pin_in(sel_pin),
        .power_down_pin_in(pd_pin), .aux_clock_config_pins_in(aux_pins), .diff_clock_in(diff_clk),
        .single_ended_reference_input_in(se_ref), .oscillator_in(osc), .timestamp_input_in(stamp),
        .sysref_in(sref), .spi_sclk_in(sclk), .spi_sdi_in(sdi), .spi_sen_n_in(sen_n),
        .spi_sdo_out(sdo), .sample_clock_out(smp), .dsp_clock_out(dsp), .lane_clock_out(lane),
        .reference_repeat_output_out(rep), .aux_clock_out_c_out(auxc), .aux_clock_out_d_out(auxd),
        .trigger_clock_output_out(trig), .sysref_capture_out(cap), .noise_supp_a_out(nsa),
        .noise_supp_b_out(nsb), .clock_ready_out(rdy));
    // rising edges per window
    always @(posedge clk_in) begin
        prev <= mon;
        for (int i = 0; i < 5; i++) begin
            if (mon[i] === 1'b1 && prev[i] === 1'b0) begin
                cnt[i]++;
            end
        end
    end
    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction
    function automatic int edges(input int cycles, input int period_ns);
        return cycles * `CLK_PERIOD_NS / period_ns;
    endfunction
    // one edge may slip across a window end
    function automatic logic near(input int got, input int expv);
        return got >= expv - 1 && got <= expv + 1;
    endfunction
    task automatic tick(input int n);
        repeat (n) @(posedge clk_in);
        #1;
    endtask
    task automatic span(input int n);
        foreach (cnt[i]) cnt[i] = 0;
        tick(n);
    endtask
    task automatic check(input logic ok, input string msg);
        n_checks++;
        if (ok !== 1'b1) begin
            miscompares++;
            $display("CHECK FAILED at %0t: %s", $time, msg);
        end
    endtask
    // 4-cycle sclk phases cover the input sync
    task automatic spi(input logic rw, input logic [14:0] a, input logic [7:0] d);
        logic [23:0] f;
        f = {rw, a, d};
        rd = 8'h00;
        sen_n = 1'b0;
        tick(4);
        for (int i = 23; i >= 0; i--) begin
            sdi = f[i];
            tick(1);
            sclk = 1'b1;
            tick(4);
            sclk = 1'b0;
            tick(4);
            if (i >= 1 && i <= 8) begin
                rd[i-1] = sdo;
            end
        end
        sen_n = 1'b1;
        sdi = 1'b0;
        tick(4);
    endtask
    task automatic end_of_test();
        $display("checks %0d mismatches %0d", n_checks, miscompares);
        if (miscompares == 0 && n_checks > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask
    initial begin
        repeat (90000) @(posedge clk_in);
        miscompares++;
        end_of_test();
    end
    initial begin
        tick(8);
        arst_n_in = 1'b1;
        tick(3);
        foreach (ra[i]) begin
            spi(1'b1, ra[i], 8'h00);
            check(rd === rv[i], "reset value");
        end
        spi(1'b1, 15'h0100, 8'h00);
        check(rd === 8'h00, "unmapped read");
        spi(1'b0, `OFS_CAL_STATE, 8'hFF);
        spi(1'b1, `OFS_CAL_STATE, 8'h00);
        check(rd[0] === 1'b0, "status took write");
        for (int k = 0; k < 4; k++) begin
            seed = lfsr(seed);
            spi(1'b0, `OFS_LOOP_NOISE, seed[7:0]);
            spi(1'b1, `OFS_LOOP_NOISE, 8'h00);
            check(rd === seed[7:0] && nsa === seed[0] && nsb === seed[1], "noise bits");
            spi(1'b0, `OFS_FEEDBACK, seed[15:8]);
            spi(1'b1, `OFS_FEEDBACK, 8'h00);
            check(rd === seed[15:8], "divider readback");
        end
        $display("register test done");
        span(400);
        check(near(cnt[4], edges(400, 64)) && cnt[0] == 0, "bypass clock");
        $display("bypass test done");
        loop_pin = 1'b1;
        aux_pins = 2'b01;
        spi(1'b0, `OFS_HOLD_RESET, 8'h01);
        spi(1'b0, `OFS_PRESCALE_OSC, 8'h25);
        spi(1'b0, `OFS_FEEDBACK, 8'h10);
        spi(1'b0, `OFS_CAL_CONTROL, 8'h01);
        spi(1'b0, `OFS_HOLD_RESET, 8'h00);
        tick(20);
        spi(1'b1, `OFS_CAL_STATE, 8'h00);
        check(rd[0] === 1'b1, "cal finished");
        spi(1'b1, `OFS_LOCK_STATE, 8'h00);
        check(rd[0] === 1'b0 && rdy === 1'b0, "ready before lock");
        for (int k = 0; k < 40 && rd[0] !== 1'b1; k++) begin
            spi(1'b1, `OFS_LOCK_STATE, 8'h00);
        end
        check(rd[0] === 1'b1 && rdy === 1'b1, "lock and ready");
        span(1920);
        check(near(cnt[4], edges(1920, FS_NS)), "loop rate");
        check(near(cnt[3], cnt[4]), "lane rate");
        check(near(cnt[0], edges(1920, REF_NS)) && cnt[2] == 0, "repeat, trigger");
        for (int m = 1; m < 4; m++) begin
            aux_pins = m[1:0];
            span(3840);
            check(near(cnt[1], edges(3840, REF_NS << (m - 1))), "aux divide");
        end
        spi(1'b0, `OFS_CLOCK_OUT, 8'h00);
        span(1920);
        check(cnt[0] == 0, "repeat disabled");
        spi(1'b0, `OFS_CLOCK_OUT, `RST_CLOCK_OUT);
        pd_pin = 1'b1;
        tick(4);
        span(1920);
        check(cnt[0] == 0 && cnt[1] == 0, "power-down");
        pd_pin = 1'b0;
        sel_pin = 1'b1;
        span(1920);
        check(near(cnt[0], edges(1920, REF_NS)), "single-ended ref");
        sel_pin = 1'b0;
        $display("loop test done");
        spi(1'b0, `OFS_TRIG_CTRL, 8'h13);
        span(1000);
        check(near(cnt[2], edges(1000, 2400)), "trigger stamp");
        spi(1'b0, `OFS_TRIG_CTRL, 8'h21);
        span(1920);
        check(near(cnt[2], cnt[3] / 2), "trigger divide");
        $display("trigger test done");
        end_of_test();
    end
endmodule // converter_clock_subsystem_ctrl_bench

// file: loop_lock_detect.v
`timescale 1ns/1ps
`include "clock_ctrl_consts.vh"
module loop_lock_detect (
    input wire clk_in,
    input wire arst_n_in,
    input wire hold_in,
    input wire ref_edge_in,
    input wire fs_edge_in,
    input wire [7:0] feedback_in,
    output reg locked_out
);
    reg [8:0] fs_count;
    reg [2:0] good;

    always @(posedge clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            fs_count <= 9'h000;
            good <= 3'h0;
            locked_out <= 1'b0;
        end else if (hold_in) begin
            fs_count <= 9'h000;
            good <= 3'h0;
            locked_out <= 1'b0;
        end else if (ref_edge_in) begin
            // n loop edges per reference period
            fs_count <= {8'h00, fs_edge_in};
            if (fs_count == {1'b0, feedback_in}) begin
                if (good != `LOCK_PERIODS) begin
                    good <= good + 3'h1;
                end
            end else begin
                good <= 3'h0;
            end
            locked_out <= (good == `LOCK_PERIODS);
        end else if (fs_edge_in && fs_count != 9'h1FF) begin
            fs_count <= fs_count + 9'h001;
        end
    end
endmodule // loop_lock_detect
